// >>> design/carrier_pkg.sv
// Constants, register map and types of the remote carrier generator
package carrier_pkg;

    // ==========================================================
    // Widths and timing
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int WIDTH_W = 9;
    localparam int STEP_CYCLES = 64;
    localparam int STEP_W = 6;
    localparam logic [STEP_W-1:0] STEP_LAST = 6'(STEP_CYCLES - 1);
    localparam int EVT_W = 2;

    // ==========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] TIMER_LOW_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] TIMER_CTRL_OFS = 4'h1;
    localparam logic [ADDR_W-1:0] LOW_WIDTH_OFS = 4'h2;
    localparam logic [ADDR_W-1:0] LOW_WIDTH_UP_OFS = 4'h3;
    localparam logic [ADDR_W-1:0] HIGH_WIDTH_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] HIGH_WIDTH_UP_OFS = 4'h5;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 4'h6;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS = 4'h7;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 4'h8;

    // ==========================================================
    // Field positions
    localparam int TOP_BIT_POS = 0;
    localparam int ENABLE_POS = 1;
    localparam int CARRIER_OFF_POS = 1;
    localparam int END_FLAG_POS = 7;
    localparam int EVT_END_POS = 0;
    localparam int EVT_START_POS = 1;

    // ==========================================================
    // Reset values
    localparam logic CARRIER_OFF_RST = 1'b1;
    localparam logic END_FLAG_RST = 1'b1;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} phase_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } regReq_t;

    typedef struct packed {
        logic [7:0] timerLow;
        logic timerTop;
        logic timerEn;
        logic endFlag;
        logic [WIDTH_W-1:0] counter;
        logic [STEP_W-1:0] prescale;
        logic [WIDTH_W-1:0] lowWidth;
        logic [WIDTH_W-1:0] highWidth;
        logic carrierOff;
        phase_t phase;
        logic [WIDTH_W-1:0] phaseCnt;
        logic [EVT_W-1:0] irqStatus;
        logic [EVT_W-1:0] irqEnable;
        logic [DATA_W-1:0] readData;
        logic pin;
        logic irq;
    } carrierState_t;

endpackage

// >>> design/remote_carrier_generator.sv
// Remote-control carrier generator gated by a 9-bit step timer
// ==============================================================
// Overview of operation
// - Nine-bit high width and low width, each in a register pair
// - Bit above the nine-bit low width always reads zero
// - Low phase lasts low width plus one, high phase high width plus one
// - Carrier reaches the pin only while the carrier-off bit is zero
// - Enabling the timer starts the carrier with its low phase
// - A high phase in progress completes before the pin goes low
// - Pin is low after reset
// - Enable off: low; enable with carrier off: high; else carrier
// - Count zero with timer enabled gives one step of 64 cycles
// - Timer-end flag set holds the pin low
// - Timer counts down once per 64 cycles; gate lasts count plus one
// - Timer stops and sets end flag at zero; clearing enable stops it with flag clear
// - Low byte write stores; control write loads counter, clears flag
// - Enable off then on reloads the stored count and restarts
`timescale 1ns/10ps
`default_nettype none

module remote_carrier_generator (
    input wire logic clock,
    input wire logic rstn,
    input wire carrier_pkg::regReq_t busReq,
    output logic [carrier_pkg::DATA_W-1:0] readData,
    output logic carrierOutPin,
    output logic irq
);
    import carrier_pkg::*;

    // ==========================================================
    // Reset release
    logic rstMeta_ff;
    logic rstSync_ff;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    // ==========================================================
    // State
    carrierState_t state_ff;
    carrierState_t nxt_state;
    logic running;
    logic carrierGate;
    logic ctrlWrite;
    logic [EVT_W-1:0] events;
    logic [EVT_W-1:0] clearMask;

    assign running = state_ff.timerEn & ~state_ff.endFlag;
    assign carrierGate = running & ~state_ff.carrierOff;
    assign ctrlWrite = busReq.wr && busReq.addr == TIMER_CTRL_OFS;

    always_comb begin
        nxt_state = state_ff;
        events = '0;
        clearMask = '0;

        // Register writes
        if (busReq.wr) begin
            case (busReq.addr)
                TIMER_LOW_OFS: begin
                    nxt_state.timerLow = busReq.wdata;
                end
                LOW_WIDTH_OFS: begin
                    nxt_state.lowWidth[7:0] = busReq.wdata;
                end
                LOW_WIDTH_UP_OFS: begin
                    nxt_state.lowWidth[8] = busReq.wdata[TOP_BIT_POS];
                end
                HIGH_WIDTH_OFS: begin
                    nxt_state.highWidth[7:0] = busReq.wdata;
                end
                HIGH_WIDTH_UP_OFS: begin
                    nxt_state.highWidth[8] = busReq.wdata[TOP_BIT_POS];
                    nxt_state.carrierOff = busReq.wdata[CARRIER_OFF_POS];
                end
                IRQ_CLEAR_OFS: begin
                    clearMask = busReq.wdata[EVT_W-1:0];
                end
                IRQ_ENABLE_OFS: begin
                    nxt_state.irqEnable = busReq.wdata[EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Step timer; stopped while enable is clear or the end flag is set; the control write reloads it
        if (running) begin
            nxt_state.prescale = state_ff.prescale + 6'h01;
            if (state_ff.prescale == STEP_LAST) begin
                if (state_ff.counter == '0) begin
                    nxt_state.endFlag = 1'b1;
                    events[EVT_END_POS] = 1'b1;
                end else begin
                    nxt_state.counter = state_ff.counter - 9'h001;
                end
            end
        end

        // Control write reloads the counter, covering 1-0-1 restarts
        if (ctrlWrite) begin
            nxt_state.timerTop = busReq.wdata[TOP_BIT_POS];
            nxt_state.timerEn = busReq.wdata[ENABLE_POS];
            nxt_state.counter = {busReq.wdata[TOP_BIT_POS],
                state_ff.timerLow};
            nxt_state.endFlag = 1'b0;
            nxt_state.prescale = '0;
            events[EVT_START_POS] = busReq.wdata[ENABLE_POS];
        end

        // Carrier phases share one down counter
        case (state_ff.phase)
            PH_IDLE: begin
                if (carrierGate) begin
                    nxt_state.phase = PH_LOW;
                    nxt_state.phaseCnt = state_ff.lowWidth;
                end
            end
            PH_LOW: begin
                if (!carrierGate) begin
                    nxt_state.phase = PH_IDLE;
                end else if (state_ff.phaseCnt == '0) begin
                    nxt_state.phase = PH_HIGH;
                    nxt_state.phaseCnt = state_ff.highWidth;
                end else begin
                    nxt_state.phaseCnt = state_ff.phaseCnt - 9'h001;
                end
            end
            PH_HIGH: begin
                // Gate drop is ignored until the high phase has run out
                if (state_ff.phaseCnt != '0) begin
                    nxt_state.phaseCnt = state_ff.phaseCnt - 9'h001;
                end else if (carrierGate) begin
                    nxt_state.phase = PH_LOW;
                    nxt_state.phaseCnt = state_ff.lowWidth;
                end else begin
                    nxt_state.phase = PH_IDLE;
                end
            end
            default: begin
                nxt_state.phase = PH_IDLE;
            end
        endcase

        // Pin follows the next state so it can leave a flip-flop
        nxt_state.pin = (nxt_state.timerEn & ~nxt_state.endFlag
            & nxt_state.carrierOff)
            | (nxt_state.phase == PH_HIGH);

        // Set wins over a clear in the same cycle
        nxt_state.irqStatus = (state_ff.irqStatus & ~clearMask) | events;
        nxt_state.irq = |(nxt_state.irqStatus & nxt_state.irqEnable);

        // Read data stands in the cycle after the strobe only
        nxt_state.readData = '0;
        if (busReq.rd) begin
            case (busReq.addr)
                TIMER_LOW_OFS: nxt_state.readData = state_ff.timerLow;
                TIMER_CTRL_OFS: begin
                    nxt_state.readData[END_FLAG_POS] = state_ff.endFlag;
                    nxt_state.readData[ENABLE_POS] = state_ff.timerEn;
                    nxt_state.readData[TOP_BIT_POS] = state_ff.timerTop;
                end
                LOW_WIDTH_OFS: nxt_state.readData = state_ff.lowWidth[7:0];
                LOW_WIDTH_UP_OFS: begin
                    nxt_state.readData[TOP_BIT_POS] = state_ff.lowWidth[8];
                end
                HIGH_WIDTH_OFS: begin
                    nxt_state.readData = state_ff.highWidth[7:0];
                end
                HIGH_WIDTH_UP_OFS: begin
                    nxt_state.readData[TOP_BIT_POS] = state_ff.highWidth[8];
                    nxt_state.readData[CARRIER_OFF_POS] = state_ff.carrierOff;
                end
                IRQ_STATUS_OFS: begin
                    nxt_state.readData[EVT_W-1:0] = state_ff.irqStatus;
                end
                IRQ_ENABLE_OFS: begin
                    nxt_state.readData[EVT_W-1:0] = state_ff.irqEnable;
                end
                default: nxt_state.readData = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            state_ff <= '0;
            state_ff.carrierOff <= CARRIER_OFF_RST;
            state_ff.endFlag <= END_FLAG_RST;
            state_ff.phase <= PH_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign readData = state_ff.readData;
    assign carrierOutPin = state_ff.pin;
    assign irq = state_ff.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync_ff);

    lowWidthTop_a:
    assert property (busReq.rd && busReq.addr == LOW_WIDTH_UP_OFS
        |=> readData[7:1] == 7'h00)
        else $error("Low width upper bits not zero");

    lowToHigh_a:
    assert property (state_ff.phase == PH_LOW && state_ff.phaseCnt == '0
        && carrierGate |=> state_ff.phase == PH_HIGH
        && state_ff.phaseCnt == $past(state_ff.highWidth))
        else $error("High phase not loaded from high width");

    startLow_a:
    assert property (state_ff.phase == PH_IDLE && carrierGate
        |=> state_ff.phase == PH_LOW && carrierOutPin == 1'b0)
        else $error("Carrier did not start low");

    highHolds_a:
    assert property (state_ff.phase == PH_HIGH && state_ff.phaseCnt != '0
        |=> state_ff.phase == PH_HIGH && carrierOutPin)
        else $error("High phase cut short");

    resetLow_a:
    assert property ($rose(rstSync_ff) |-> !carrierOutPin)
        else $error("Pin not low after reset");

    steadyHigh_a:
    assert property (running && state_ff.carrierOff
        && $past(running) |-> carrierOutPin)
        else $error("Pin not steady high");

    endForcesLow_a:
    assert property (state_ff.endFlag && state_ff.phase != PH_HIGH
        |-> !carrierOutPin)
        else $error("Pin not low with end flag set");

    countStep_a:
    assert property (running && !ctrlWrite && state_ff.prescale == STEP_LAST
        && state_ff.counter != '0
        |=> state_ff.counter == $past(state_ff.counter) - 9'h001)
        else $error("Timer step wrong");

    endAtZero_a:
    assert property (running && !ctrlWrite && state_ff.prescale == STEP_LAST
        && state_ff.counter == '0 |=> state_ff.endFlag ##1 !irq
        || state_ff.irqStatus[EVT_END_POS])
        else $error("Timer did not end at zero");

    ctrlLoad_a:
    assert property (ctrlWrite |=> !state_ff.endFlag
        && state_ff.counter == {$past(busReq.wdata[TOP_BIT_POS]),
        $past(state_ff.timerLow)})
        else $error("Control write did not load counter");

    oneStep_a:
    assert property (ctrlWrite && busReq.wdata[ENABLE_POS]
        && busReq.wdata[TOP_BIT_POS] == 1'b0 && state_ff.timerLow == 8'h00
        ##1 !busReq.wr [*8] |-> !state_ff.endFlag)
        else $error("Zero count ended too early");

    countHold_a:
    assert property (running && !ctrlWrite && state_ff.prescale != STEP_LAST
        |=> state_ff.counter == $past(state_ff.counter))
        else $error("Timer moved inside a step");

    timerFrozen_a:
    assert property (!state_ff.timerEn && !ctrlWrite
        |=> $stable(state_ff.counter) && $stable(state_ff.endFlag))
        else $error("Timer moved while disabled");

    carrierOffIdle_a:
    assert property (state_ff.phase == PH_IDLE && !carrierGate
        |=> state_ff.phase == PH_IDLE)
        else $error("Carrier started while gated off");

    enableOffLow_a:
    assert property (!state_ff.timerEn && state_ff.phase != PH_HIGH
        |-> !carrierOutPin)
        else $error("Pin not low with enable off");

    highToLow_a:
    assert property (state_ff.phase == PH_HIGH && state_ff.phaseCnt == '0
        && carrierGate |=> state_ff.phase == PH_LOW
        && state_ff.phaseCnt == $past(state_ff.lowWidth))
        else $error("Low phase not loaded from low width");

endmodule

`default_nettype wire

// >>> testbench/emitter_driver_model.sv
// Emitter driver model that times the levels seen on the carrier pin
`timescale 1ns/10ps
`default_nettype none

module emitter_driver_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic drive,
    output logic [15:0] lowRun,
    output logic [15:0] highRun
);
    // ==========================================================
    // Run-length capture
    // An unknown level counts as a change, so it never hides in a run
    logic prevLevel;
    logic [15:0] runLen;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prevLevel <= 1'b0;
            runLen <= 16'h0001;
            lowRun <= 16'h0000;
            highRun <= 16'h0000;
        end else if (drive === prevLevel) begin
            runLen <= runLen + 16'h0001;
        end else begin
            if (prevLevel) begin
                highRun <= runLen;
            end else begin
                lowRun <= runLen;
            end
            prevLevel <= drive;
            runLen <= 16'h0001;
        end
    end
endmodule

`default_nettype wire

// >>> testbench/remote_carrier_generator_tb.sv
// Register-level testbench of the remote carrier generator
`timescale 1ns/10ps
`default_nettype none

module remote_carrier_generator_tb;
    import carrier_pkg::*;
    // ==========================================================
    // Signals
    logic clock = 1'b0;
    logic rstn = 1'b0;
    regReq_t busReq = '0;
    logic [DATA_W-1:0] readData;
    logic carrierOutPin;
    logic irq;
    logic [15:0] lowRun;
    logic [15:0] highRun;
    int err_total = 0;
    int n_compared = 0;

    always #5 clock = ~clock;

    remote_carrier_generator i_dut (
        .clock(clock),
        .rstn(rstn),
        .busReq(busReq),
        .readData(readData),
        .carrierOutPin(carrierOutPin),
        .irq(irq)
    );

    emitter_driver_model i_emitter (
        .clock(clock),
        .rstn(rstn),
        .drive(carrierOutPin),
        .lowRun(lowRun),
        .highRun(highRun)
    );

    // ==========================================================
    // Tasks
    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        busReq.addr <= a;
        busReq.wdata <= d;
        busReq.wr <= 1'b1;
        @(posedge clock);
        busReq.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp,
                      input string what);
        @(posedge clock);
        busReq.addr <= a;
        busReq.rd <= 1'b1;
        @(posedge clock);
        busReq.rd <= 1'b0;
        #1;
        check(what, 16'(exp), 16'(readData));
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // ==========================================================
    // Watchdog
    initial begin
        repeat (50000) @(posedge clock);
        err_total++;
        give_verdict;
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clock);
        #1;
        check("pin in reset", 16'h0, 16'(carrierOutPin));
        @(posedge clock);
        rstn <= 1'b1;
        idle(3);
        check("pin after reset", 16'h0, 16'(carrierOutPin));
        rd(TIMER_CTRL_OFS, 8'h80, "ctrl reset");
        rd(HIGH_WIDTH_UP_OFS, 8'h02, "high upper reset");
        rd(IRQ_ENABLE_OFS, 8'h00, "irq enable reset");
        wr(LOW_WIDTH_UP_OFS, 8'hff);
        rd(LOW_WIDTH_UP_OFS, 8'h01, "low upper top bit");
        wr(4'hf, 8'hff);
        rd(4'h9, 8'h00, "unmapped read");
        // Carrier on, L=2 H=3, count 1: gate of 128 cycles
        wr(LOW_WIDTH_OFS, 8'h02);
        wr(LOW_WIDTH_UP_OFS, 8'h00);
        wr(HIGH_WIDTH_OFS, 8'h03);
        wr(HIGH_WIDTH_UP_OFS, 8'h00);
        wr(TIMER_LOW_OFS, 8'h01);
        rd(TIMER_CTRL_OFS, 8'h80, "low byte only stored");
        wr(TIMER_CTRL_OFS, 8'h02);
        idle(2);
        check("first phase low", 16'h0, 16'(carrierOutPin));
        idle(56);
        rd(TIMER_CTRL_OFS, 8'h02, "gate running");
        check("low run", 16'd3, lowRun);
        check("high run", 16'd4, highRun);
        idle(90);
        rd(TIMER_CTRL_OFS, 8'h82, "gate ended");
        check("pin after end", 16'h0, 16'(carrierOutPin));
        check("last high run", 16'd4, highRun);
        check("irq masked", 16'h0, 16'(irq));
        rd(IRQ_STATUS_OFS, 8'h03, "irq status");
        wr(IRQ_ENABLE_OFS, 8'h01);
        idle(2);
        check("irq enabled", 16'h1, 16'(irq));
        wr(IRQ_CLEAR_OFS, 8'h03);
        idle(2);
        check("irq cleared", 16'h0, 16'(irq));
        rd(IRQ_STATUS_OFS, 8'h00, "status cleared");
        // Carrier off, count 0: one steady high step
        wr(TIMER_CTRL_OFS, 8'h00);
        wr(HIGH_WIDTH_UP_OFS, 8'h02);
        wr(TIMER_LOW_OFS, 8'h00);
        wr(TIMER_CTRL_OFS, 8'h02);
        idle(30);
        check("steady high", 16'h1, 16'(carrierOutPin));
        idle(60);
        check("high step", 16'(STEP_CYCLES), highRun);
        check("pin with end flag", 16'h0, 16'(carrierOutPin));
        rd(TIMER_CTRL_OFS, 8'h82, "single step end");
        // Enable cleared mid-count, then restart from stored count
        wr(HIGH_WIDTH_UP_OFS, 8'h00);
        wr(TIMER_LOW_OFS, 8'h05);
        rd(TIMER_LOW_OFS, 8'h05, "low byte readback");
        wr(TIMER_CTRL_OFS, 8'h02);
        idle(30);
        wr(TIMER_CTRL_OFS, 8'h00);
        idle(8);
        check("pin enable off", 16'h0, 16'(carrierOutPin));
        check("cut high run", 16'd4, highRun);
        idle(400);
        rd(TIMER_CTRL_OFS, 8'h00, "stopped not ended");
        wr(TIMER_CTRL_OFS, 8'h02);
        idle(300);
        rd(TIMER_CTRL_OFS, 8'h02, "restarted");
        idle(150);
        rd(TIMER_CTRL_OFS, 8'h82, "restart end");
        give_verdict;
    end
endmodule

`default_nettype wire
